// [logic/serial_port_top.sv]
// Serial port with shift mode, async modes and baud timer
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module serial_port_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [uart_pkg::ADDR_W-1:0] addr_i,
  input wire logic [uart_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [uart_pkg::DATA_W-1:0] rdata_o,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o,
  input wire logic baud_timer_clock_pin_i,
  input wire logic baud_timer_ext_input_i,
  output logic tx_buf_ready_o
);
  import uart_pkg::*;

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic [2:0] rxd_s;
    logic [2:0] t2_s;
    logic [2:0] baud_timer_ext_input_s;
    logic sm0;
    logic sm1;
    logic sm2;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic fe;
    logic fe_sel;
    logic dbl;
    logic run;
    logic extclk;
    logic extf;
    logic [15:0] rld;
    logic [15:0] cnt;
    logic [7:0] rbuf;
    logic [1:0][8:0] fmem;
    logic wptr;
    logic rptr;
    logic [1:0] fcnt;
    logic div2;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx16;
    logic tx_line_n;
    logic m0_on;
    logic m0_rx;
    logic [2:0] m0_ph;
    logic [2:0] m0_bits;
    logic [7:0] m0_sh;
    logic sclk_n;
    rx_state_t rx_st;
    logic [3:0] rx16;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic s7;
    logic s8;
  } state_t;

  state_t st;
  state_t next_st;
  mode_t mode;
  logic tinc;
  logic ovf;
  logic tick16;
  logic txb;
  logic rx9;
  logic rxs;
  logic maj;
  logic fin;
  logic ninth;
  logic push;
  logic has;
  logic go_tx;
  logic go_rx;
  logic tx_free;
  logic pop;
  logic [8:0] head;

  // ---------------------------------------------
  // Derived strobes
  // ---------------------------------------------
  assign mode = mode_t'({st.sm0, st.sm1});
  assign tinc = st.run & (st.extclk ? (st.t2_s[2] & ~st.t2_s[1]) : 1'b1);
  assign ovf = tinc & (st.cnt == CNT_MAX);
  assign tick16 = (mode == MODE_FIX9) ? (st.dbl | st.div2) : ovf;
  assign txb = tick16 & (st.tx16 == TICK_LAST);
  assign rx9 = tick16 & (st.rx16 == SMP_C);
  assign rxs = st.rxd_s[1];
  assign maj = (st.s7 & st.s8) | (st.s7 & rxs) | (st.s8 & rxs);
  assign fin = rx9 & (st.rx_st == RX_STOP);
  assign ninth = (mode == MODE_ASYNC8) ? maj : st.rx_sh[8];
  assign push = wr_i & (addr_i == ADDR_SBUF) & (st.fcnt != FIFO_FULL);
  assign has = st.fcnt != FIFO_EMPTY;
  assign head = st.fmem[st.rptr];
  assign go_tx = (mode == MODE_SHIFT) & ~st.m0_on & has;
  assign go_rx = (mode == MODE_SHIFT) & ~st.m0_on & ~has & st.ren & ~st.ri;
  assign tx_free = ~st.tx_busy | (st.tx_bits == 4'h0);
  assign pop = go_tx | (txb & tx_free & has & (mode != MODE_SHIFT));

  assign rdata_o = st.rdata;
  assign rxd_o = st.m0_sh[0];
  assign rxd_oe_o = st.m0_on & ~st.m0_rx;
  assign txd_o = (mode == MODE_SHIFT) ? ~st.sclk_n : ~st.tx_line_n;
  assign tx_buf_ready_o = st.fcnt != FIFO_FULL;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rdata = '0;
    next_st.rxd_s = {st.rxd_s[1:0], rxd_i};
    next_st.t2_s = {st.t2_s[1:0], baud_timer_clock_pin_i};
    next_st.baud_timer_ext_input_s = {st.baud_timer_ext_input_s[1:0], baud_timer_ext_input_i};
    next_st.div2 = ~st.div2;
    // Timer
    if (ovf)
    begin
      next_st.cnt = st.rld;
    end
    else if (tinc)
    begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    // Register writes
    if (wr_i)
    begin
      if (addr_i == ADDR_SERIAL_CONTROL_REG)
      begin
        if (st.fe_sel)
        begin
          next_st.fe = wdata_i[SC_SM0];
        end
        else
        begin
          next_st.sm0 = wdata_i[SC_SM0];
        end
        next_st.sm1 = wdata_i[SC_SM1];
        next_st.sm2 = wdata_i[SC_SM2];
        next_st.ren = wdata_i[SC_REN];
        next_st.tb8 = wdata_i[SC_TB8];
        next_st.rb8 = wdata_i[SC_RB8];
        next_st.ti = wdata_i[SC_TI];
        next_st.ri = wdata_i[SC_RI];
      end
      else if (addr_i == ADDR_PCON)
      begin
        next_st.dbl = wdata_i[PC_DBL];
        next_st.fe_sel = wdata_i[PC_FESEL];
      end
      else if (addr_i == ADDR_TCTL)
      begin
        next_st.extf = wdata_i[TC_EXTF];
        next_st.run = wdata_i[TC_RUN];
        next_st.extclk = wdata_i[TC_EXTCLK];
      end
      else if (addr_i == ADDR_RLDL)
      begin
        next_st.rld[7:0] = wdata_i;
      end
      else if (addr_i == ADDR_RLDH)
      begin
        next_st.rld[15:8] = wdata_i;
      end
      else if (addr_i == ADDR_CNTL)
      begin
        next_st.cnt[7:0] = wdata_i;
      end
      else if (addr_i == ADDR_CNTH)
      begin
        next_st.cnt[15:8] = wdata_i;
      end
    end
    // Capture input only flags an event
    if (st.baud_timer_ext_input_s[2] & ~st.baud_timer_ext_input_s[1])
    begin
      next_st.extf = 1'b1;
    end
    // Transmit buffer
    if (push)
    begin
      next_st.fmem[st.wptr] = {st.tb8, wdata_i};
      next_st.wptr = ~st.wptr;
    end
    if (pop)
    begin
      next_st.rptr = ~st.rptr;
    end
    if (push & ~pop)
    begin
      next_st.fcnt = st.fcnt + 2'h1;
    end
    else if (pop & ~push)
    begin
      next_st.fcnt = st.fcnt - 2'h1;
    end
    // Shift register mode
    if (go_tx | go_rx)
    begin
      next_st.m0_on = 1'b1;
      next_st.m0_rx = go_rx;
      next_st.m0_ph = '0;
      next_st.m0_bits = '0;
      next_st.m0_sh = go_tx ? head[7:0] : 8'hFF;
      next_st.sclk_n = 1'b1;
    end
    else if (st.m0_on)
    begin
      next_st.m0_ph = (st.m0_ph == M0_LAST) ? 3'h0 : st.m0_ph + 3'h1;
      next_st.sclk_n = next_st.m0_ph < M0_HALF;
      if (st.m0_ph == M0_LAST)
      begin
        next_st.m0_sh = {st.m0_rx ? rxs : 1'b1, st.m0_sh[7:1]};
        next_st.m0_bits = st.m0_bits + 3'h1;
        if (st.m0_bits == M0_BITS)
        begin
          next_st.m0_on = 1'b0;
          next_st.sclk_n = 1'b0;
          if (st.m0_rx)
          begin
            next_st.rbuf = {rxs, st.m0_sh[7:1]};
            next_st.ri = 1'b1;
          end
          else
          begin
            next_st.ti = 1'b1;
          end
        end
      end
    end
    // Asynchronous transmitter
    if (mode == MODE_SHIFT)
    begin
      next_st.tx_busy = 1'b0;
      next_st.tx_line_n = 1'b0;
    end
    else
    begin
      if (tick16)
      begin
        next_st.tx16 = st.tx16 + 4'h1;
      end
      if (txb)
      begin
        if (~tx_free)
        begin
          next_st.tx_line_n = ~st.tx_sh[0];
          next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
          next_st.tx_bits = st.tx_bits - 4'h1;
          if (st.tx_bits == 4'h1)
          begin
            next_st.ti = 1'b1;
          end
        end
        else if (has)
        begin
          next_st.tx_line_n = 1'b1;
          next_st.tx_busy = 1'b1;
          next_st.tx_sh = {1'b1, (mode == MODE_ASYNC8) | head[8], head[7:0]};
          next_st.tx_bits = (mode == MODE_ASYNC8) ? TX_LEN8 : TX_LEN9;
        end
        else
        begin
          next_st.tx_busy = 1'b0;
          next_st.tx_line_n = 1'b0;
        end
      end
    end
    // Asynchronous receiver
    if ((mode == MODE_SHIFT) | ~st.ren)
    begin
      next_st.rx_st = RX_IDLE;
    end
    else
    begin
      case (st.rx_st)
        RX_IDLE:
        begin
          if (st.rxd_s[2] & ~rxs)
          begin
            next_st.rx_st = RX_START;
            next_st.rx16 = '0;
          end
        end
        default:
        begin
          if (tick16)
          begin
            next_st.rx16 = st.rx16 + 4'h1;
            if (st.rx16 == SMP_A)
            begin
              next_st.s7 = rxs;
            end
            if (st.rx16 == SMP_B)
            begin
              next_st.s8 = rxs;
            end
          end
          if (rx9)
          begin
            case (st.rx_st)
              RX_START:
              begin
                next_st.rx_st = maj ? RX_IDLE : RX_DATA;
                next_st.rx_bits = '0;
              end
              RX_DATA:
              begin
                next_st.rx_sh = {maj, st.rx_sh[8:1]};
                next_st.rx_bits = st.rx_bits + 4'h1;
                if (st.rx_bits == ((mode == MODE_ASYNC8) ? RX_LAST8 : RX_LAST9))
                begin
                  next_st.rx_st = RX_STOP;
                end
              end
              default:
              begin
                next_st.rx_st = RX_IDLE;
                if (~maj)
                begin
                  next_st.fe = 1'b1;
                end
                if (~st.ri & (~st.sm2 | ninth))
                begin
                  next_st.rbuf = (mode == MODE_ASYNC8) ? st.rx_sh[8:1] : st.rx_sh[7:0];
                  next_st.rb8 = ninth;
                  next_st.ri = 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end
    // Register reads
    if (rd_i)
    begin
      if (addr_i == ADDR_SERIAL_CONTROL_REG)
      begin
        next_st.rdata[SC_SM0] = st.fe_sel ? st.fe : st.sm0;
        next_st.rdata[SC_SM1] = st.sm1;
        next_st.rdata[SC_SM2] = st.sm2;
        next_st.rdata[SC_REN] = st.ren;
        next_st.rdata[SC_TB8] = st.tb8;
        next_st.rdata[SC_RB8] = st.rb8;
        next_st.rdata[SC_TI] = st.ti;
        next_st.rdata[SC_RI] = st.ri;
      end
      else if (addr_i == ADDR_SBUF)
      begin
        next_st.rdata = st.rbuf;
      end
      else if (addr_i == ADDR_PCON)
      begin
        next_st.rdata[PC_DBL] = st.dbl;
        next_st.rdata[PC_FESEL] = st.fe_sel;
      end
      else if (addr_i == ADDR_TCTL)
      begin
        next_st.rdata[TC_EXTF] = st.extf;
        next_st.rdata[TC_RUN] = st.run;
        next_st.rdata[TC_EXTCLK] = st.extclk;
      end
      else if (addr_i == ADDR_RLDL)
      begin
        next_st.rdata = st.rld[7:0];
      end
      else if (addr_i == ADDR_RLDH)
      begin
        next_st.rdata = st.rld[15:8];
      end
      else if (addr_i == ADDR_CNTL)
      begin
        next_st.rdata = st.cnt[7:0];
      end
      else if (addr_i == ADDR_CNTH)
      begin
        next_st.rdata = st.cnt[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_shift_clk_period: assert property ($fell(txd_o) && mode == MODE_SHIFT |-> !txd_o [*3] ##1 txd_o [*3])
    else $error("shift clock period wrong");
  a_shift_eight_bits: assert property ($rose(st.m0_on) |-> ##47 st.m0_on ##1 !st.m0_on)
    else $error("shift transfer length wrong");
  a_ti_at_stop: assert property ($rose(st.ti) && !$past(wr_i) |-> txd_o)
    else $error("transmit flag not at stop");
  a_ri_sw_clear: assert property (st.ri && !(wr_i && addr_i == ADDR_SERIAL_CONTROL_REG) |=> st.ri)
    else $error("receive flag lost");
  a_start_reject: assert property (rx9 && st.rx_st == RX_START && maj |=> st.rx_st == RX_IDLE)
    else $error("false start accepted");
  a_frame_discard: assert property (fin && st.ri |=> $stable(st.rbuf))
    else $error("buffer overwritten");
  a_fe_readback: assert property (rd_i && addr_i == ADDR_SERIAL_CONTROL_REG |=> rdata_o[SC_SM0] == $past(st.fe_sel ? st.fe : st.sm0))
    else $error("top control bit wrong");
  a_timer_reload: assert property (ovf && !wr_i |=> st.cnt == $past(st.rld))
    else $error("timer reload wrong");
  a_tx_idle_high: assert property (mode != MODE_SHIFT && !st.tx_busy |-> txd_o)
    else $error("line not idle high");

  c_rx_load: cover property (fin && !st.ri ##1 st.ri);
  c_shift_done: cover property ($fell(st.m0_on));
  c_start_reject: cover property (rx9 && st.rx_st == RX_START && maj);
  c_buf_full: cover property (!tx_buf_ready_o);

endmodule // serial_port_top

// [logic/uart_pkg.sv]
// Constants and types of the serial port with its baud timer
package uart_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ---------------------------------------------
  // Register map
  // ---------------------------------------------
  localparam logic [7:0] ADDR_SERIAL_CONTROL_REG = 8'h98;
  localparam logic [7:0] ADDR_SBUF = 8'h99;
  localparam logic [7:0] ADDR_PCON = 8'h87;
  localparam logic [7:0] ADDR_TCTL = 8'hC8;
  localparam logic [7:0] ADDR_RLDL = 8'hCA;
  localparam logic [7:0] ADDR_RLDH = 8'hCB;
  localparam logic [7:0] ADDR_CNTL = 8'hCC;
  localparam logic [7:0] ADDR_CNTH = 8'hCD;

  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int SC_RI = 0;
  localparam int SC_TI = 1;
  localparam int SC_RB8 = 2;
  localparam int SC_TB8 = 3;
  localparam int SC_REN = 4;
  localparam int SC_SM2 = 5;
  localparam int SC_SM1 = 6;
  localparam int SC_SM0 = 7;
  localparam int PC_FESEL = 6;
  localparam int PC_DBL = 7;
  localparam int TC_EXTCLK = 1;
  localparam int TC_RUN = 2;
  localparam int TC_EXTF = 6;

  // ---------------------------------------------
  // Timing counts
  // ---------------------------------------------
  localparam logic [2:0] M0_LAST = 3'h5;
  localparam logic [2:0] M0_HALF = 3'h3;
  localparam logic [2:0] M0_BITS = 3'h7;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TX_LEN8 = 4'h9;
  localparam logic [3:0] TX_LEN9 = 4'hA;
  localparam logic [3:0] RX_LAST8 = 4'h7;
  localparam logic [3:0] RX_LAST9 = 4'h8;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] FIFO_EMPTY = 2'h0;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_FIX9 = 2'b10,
    MODE_VAR9 = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

endpackage

// [tb/serial_far_end.sv]
// Model of the remote serial device on the receive and transmit lines
`timescale 1ns/1ps
module serial_far_end (
  input wire logic clk_i,
  input wire logic shift_mode_i,
  input wire logic [7:0] bit_clks_i,
  input wire logic [3:0] data_bits_i,
  input wire logic txd_i,
  input wire logic shift_data_i,
  output logic line_o
);
  int got[$];
  int gap;
  int k;
  time last;
  logic [9:0] w;
  logic [7:0] sh;

  initial
  begin
    line_o = 1'b1;
    k = 0;
    gap = 0;
    last = 0;
  end

  // ---------------------------------------------
  // Capture of transmitted frames
  // ---------------------------------------------
  initial
  forever
  begin
    @(negedge txd_i);
    if (!shift_mode_i)
    begin
      w = '0;
      repeat (bit_clks_i / 2) @(posedge clk_i);
      for (int i = 0; i <= int'(data_bits_i); i++)
      begin
        repeat (bit_clks_i) @(posedge clk_i);
        w[i] = txd_i;
      end
      got.push_back(int'(w));
    end
  end

  // Shift mode: data taken at each rising shift clock
  always @(posedge txd_i)
    if (shift_mode_i && $time > 0)
    begin
      gap = int'(($time - last) / 10);
      last = $time;
      sh = {shift_data_i, sh[7:1]};
      k = k + 1;
      if (k == 8)
      begin
        got.push_back(int'(sh));
        k = 0;
      end
    end

  // ---------------------------------------------
  // Frame sender; line idles high
  // ---------------------------------------------
  task automatic send(input logic [9:0] bits, input int n, input int p);
    line_o <= 1'b0;
    repeat (p) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= bits[i];
      repeat (p) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  // Shift mode receive: next bit put on the line at each falling shift clock
  task automatic shift_feed(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge txd_i);
      line_o <= v[i];
    end
    @(posedge txd_i);
    line_o <= 1'b1;
  endtask

  // Short low pulse that is no start bit
  task automatic glitch(input int n);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule // serial_far_end

// [tb/serial_port_with_timer_baud_tb.sv]
// Self-checking testbench of the serial port with baud timer
`timescale 1ns/1ps
module serial_port_with_timer_baud_tb;
  import uart_pkg::*;
  logic clk_sys_i, rst_n_i, wr_i, rd_i, rxd_i, rxd_o, rxd_oe_o, txd_o, pin_clk, ext_in, tx_buf_ready_o, far_line;
  logic [7:0] addr_i, wdata_i, rdata_o, d, e, bit_clks;
  logic [3:0] data_bits;
  logic shift_mode, acc;
  int seed, miscompares, samples_checked;
  int exp_q[$];

  // Shared line: the port drives it in shift mode only
  assign rxd_i = rxd_oe_o ? rxd_o : far_line;

  serial_port_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
    .txd_o(txd_o), .baud_timer_clock_pin_i(pin_clk), .baud_timer_ext_input_i(ext_in),
    .tx_buf_ready_o(tx_buf_ready_o));

  serial_far_end u_far (.clk_i(clk_sys_i), .shift_mode_i(shift_mode), .bit_clks_i(bit_clks),
    .data_bits_i(data_bits), .txd_i(txd_o), .shift_data_i(rxd_o), .line_o(far_line));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    #1 acc = tx_buf_ready_o;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(16'(rdata_o), 16'(x));
  endtask

  task automatic check_frames();
    int c;
    c = 0;
    while (u_far.got.size() < exp_q.size() && c < 3000)
    begin
      @(posedge clk_sys_i);
      c++;
    end
    chk(16'(u_far.got.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0 && u_far.got.size() > 0)
      chk(16'(u_far.got.pop_front()), 16'(exp_q.pop_front()));
    exp_q.delete();
  endtask

  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #800000;
    miscompares++;
    give_verdict();
  end

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial
  begin
    seed = 32'hDF3A91ED;
    {rst_n_i, wr_i, rd_i, pin_clk, ext_in} = 5'h03;
    {addr_i, wdata_i} = 16'h0000;
    {shift_mode, bit_clks, data_bits} = {1'b1, 8'h06, 4'h8};
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h00);
    rd_chk(8'h10, 8'h00);
    d = 8'($random(seed));
    wr(ADDR_SBUF, d);
    exp_q.push_back(int'(d));
    check_frames();
    chk(16'(u_far.gap), 16'h0006);
    repeat (8) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h02);
    shift_mode <= 1'b0;
    bit_clks <= 8'h10;
    data_bits <= 4'h9;
    wr(ADDR_PCON, 8'h80);
    wr(ADDR_SERIAL_CONTROL_REG, 8'h98);
    for (int i = 0; i < 5; i++)
    begin
      d = 8'($random(seed));
      wr(ADDR_SBUF, d);
      if (acc === 1'b1) exp_q.push_back(int'({2'b11, d}));
    end
    #1 chk(16'(tx_buf_ready_o), 16'h0000);
    check_frames();
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h9A);
    wr(ADDR_SERIAL_CONTROL_REG, 8'h90);
    d = 8'($random(seed));
    e = 8'($random(seed));
    u_far.send({2'b10, d}, 10, 16);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h91);
    rd_chk(ADDR_SBUF, d);
    u_far.send({2'b11, e}, 10, 16);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(ADDR_SBUF, d);
    wr(ADDR_SERIAL_CONTROL_REG, 8'hB0);
    u_far.send({2'b10, e}, 10, 16);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'hB0);
    u_far.send({2'b11, e}, 10, 16);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'hB5);
    rd_chk(ADDR_SBUF, e);
    wr(ADDR_SERIAL_CONTROL_REG, 8'h90);
    u_far.glitch(4);
    repeat (200) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h90);
    wr(ADDR_PCON, 8'hC0);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h10);
    u_far.send({2'b00, d}, 10, 16);
    repeat (20) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h91);
    wr(ADDR_PCON, 8'h80);
    wr(ADDR_TCTL, 8'h06);
    for (int i = 0; i < 3; i++)
    begin
      pin_clk <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      pin_clk <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
    end
    wr(ADDR_TCTL, 8'h00);
    rd_chk(ADDR_CNTL, 8'h03);
    wr(ADDR_CNTL, 8'hFE);
    wr(ADDR_CNTH, 8'hFF);
    wr(ADDR_RLDL, 8'hFE);
    wr(ADDR_RLDH, 8'hFF);
    wr(ADDR_TCTL, 8'h04);
    ext_in <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    ext_in <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd_chk(ADDR_TCTL, 8'h44);
    wr(ADDR_SERIAL_CONTROL_REG, 8'h50);
    bit_clks <= 8'h20;
    data_bits <= 4'h8;
    d = 8'($random(seed));
    wr(ADDR_SBUF, d);
    exp_q.push_back(int'({2'b01, d}));
    check_frames();
    wr(ADDR_SERIAL_CONTROL_REG, 8'h50);
    u_far.send({2'b01, e}, 9, 32);
    repeat (40) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h55);
    rd_chk(ADDR_SBUF, e);
    shift_mode <= 1'b1;
    d = 8'($random(seed));
    fork
      u_far.shift_feed(d);
      wr(ADDR_SERIAL_CONTROL_REG, 8'h10);
    join
    repeat (8) @(posedge clk_sys_i);
    rd_chk(ADDR_SERIAL_CONTROL_REG, 8'h11);
    rd_chk(ADDR_SBUF, d);
    give_verdict();
  end
endmodule // serial_port_with_timer_baud_tb
